// file: dv/lbc_monitor.sv
// assertion checker for the loopback two activation control
`timescale 1ns/100ps
`include "lbc_defines.svh"
module lbc_monitor
  import lbc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire lbc_nt_out_t nt_out_q,
  input wire lbc_lt_out_t lt_out_q,
  input wire logic        nt_budget_expired,
  input wire logic        lt_budget_expired
);
  wire deact_req = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr == `LBC_ADDR_LT_EVENT
    && s_axi_wdata[`LBC_EV_DEACT_REQ] && s_axi_wstrb[0];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  rst_values_a: assert property (
    $rose(aresetn) |-> nt_out_q == 5'h00 && lt_out_q == 7'h49
    && !s_axi_bvalid && !s_axi_rvalid) else $error("bad reset outputs");
  deact_entry_a: assert property (
    deact_req && !lt_out_q.lt_silence |-> ##[1:5]
    !lt_out_q.deactivation_bit) else $error("no deactivation bit 0");
  pend_quiet_a: assert property (
    !lt_out_q.deactivation_bit |-> !lt_out_q.activation_bit)
    else $error("activation answered while pending");
  ind_silence_a: assert property (
    $rose(lt_out_q.deact_indication) |-> ##[1:4] lt_out_q.lt_silence)
    else $error("no silence after indication");
  eoc_gate_a: assert property (
    lt_out_q.eoc_loopback_cmd |-> lt_out_q.eoc_allowed)
    else $error("command before frame sync");
  loop_entry_a: assert property (
    $rose(nt_out_q.te_block) |-> nt_out_q.send_info2
    && !nt_out_q.substitute_data) else $error("bad loop entry");
  sub_block_a: assert property (
    nt_out_q.substitute_data |-> nt_out_q.te_block)
    else $error("substitution without blocking");
  loss_return_a: assert property (
    $fell(nt_out_q.substitute_data) && nt_out_q.te_block |->
    nt_out_q.send_info2 && !nt_out_q.activation_bit)
    else $error("bad return to loop synced");
  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("write response dropped");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  cover property (lt_out_q.deact_indication);
  cover property (nt_out_q.substitute_data && nt_out_q.send_info4);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : lbc_monitor

bind lbc_loopback_ctrl lbc_monitor i_mon (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .nt_out_q, .lt_out_q, .nt_budget_expired, .lt_budget_expired
);

// file: dv/lbc_net_model.sv
// network side model: register bus master of the exchange
`timescale 1ns/100ps
module lbc_net_model (
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(negedge aclk);
      if (!s_axi_awvalid && !s_axi_wvalid) break;
      ga = s_axi_awready;
      gw = s_axi_wready;
      @(posedge aclk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(negedge aclk);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    s_axi_wdata  <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(negedge aclk);
    while (!s_axi_arready) @(negedge aclk);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(negedge aclk);
    while (!s_axi_rvalid) @(negedge aclk);
    d = s_axi_rdata;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : lbc_net_model

// file: dv/testbench.sv
// self-checking bench for the loopback two activation control
`timescale 1ns/100ps
`include "lbc_defines.svh"
module testbench
  import lbc_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        nt_budget_expired, lt_budget_expired;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, s;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] lfsr;
  lbc_nt_out_t nt_out_q;
  lbc_lt_out_t lt_out_q;
  int          n_errors, checks;
  // per step: address, event bit, nt state, lt state, block/sub, zero data
  int          steps[$] = '{'h1811101, 'h1801201, 'h1412201, 'h1404221,
    'h0024420,
    'h1416430, 'h1446430, 'h1424420, 'h1854221, 'h1461201, 'h1841300,
    'h1413300, 'h1443300, 'h1404320, 'h1461300, 'h182750F, 'h143750F,
    'h184750F, 'h183750F, 'h183750F, 'h1837001, 'h1450001};

  lbc_loopback_ctrl #(.WARM_SPLIT_CYC(20), .COLD_NT_CYC(40),
    .COLD_LT_CYC(80)) i_lbc_loopback_ctrl (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .nt_out_q, .lt_out_q, .nt_budget_expired,
    .lt_budget_expired);
  lbc_net_model i_net (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    $display("ERROR watchdog expected end seen hang");
    summarize();
  end
  initial begin
    aresetn  = 1'b0;
    n_errors = 0;
    checks   = 0;
    lfsr     = 16'h0058;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("lt_out_q", 32'h49, 32'(lt_out_q));
    check("nt_out_q", 32'h0, 32'(nt_out_q));
    i_net.rd(`LBC_ADDR_CTRL, rv);
    check("ctrl reset", `LBC_CTRL_RESET, rv);
    lfsr = lfsr_next(lfsr);
    i_net.wr(`LBC_ADDR_CTRL, {30'h0, lfsr[1:0]});
    i_net.rd(`LBC_ADDR_CTRL, rv);
    check("ctrl", {30'h0, lfsr[1:0]}, rv);
    lfsr = lfsr_next(lfsr);
    i_net.wr(8'h1C, {lfsr, ~lfsr});
    i_net.rd(8'h1C, rv);
    check("unmapped", 32'h0, rv);
    $display("register test done");
    foreach (steps[i]) begin
      s = steps[i];
      i_net.wr(s[27:20], 32'h1 << s[19:16]);
      repeat (4) @(posedge aclk);
      i_net.rd(`LBC_ADDR_NT_STATE, rv);
      check("nt state", 32'(s[15:12]), rv);
      i_net.rd(`LBC_ADDR_LT_STATE, rv);
      check("lt state", 32'(s[11:8]), rv);
      @(negedge aclk);
      rv = {30'h0, nt_out_q.te_block, nt_out_q.substitute_data};
      check("block sub", 32'(s[7:4]), rv);
      rv = 32'(lt_out_q.zero_data);
      if (s[3:0] != 4'hF) check("zero data", 32'(s[3:0]), rv);
      rv = 32'(lt_out_q.eoc_loopback_cmd);
      if (i == 1) check("eoc command", 32'h1, rv);
      rv = 32'(lt_out_q.lt_silence);
      if (i == 20) check("silence", 32'h1, rv);
    end
    $display("event step test done");
    i_net.wr(`LBC_ADDR_LT_EVENT, 32'h0000_0002);
    repeat (40) @(posedge aclk);
    @(negedge aclk);
    check("lt budget", 32'h1, 32'(lt_budget_expired));
    check("nt budget", 32'h0, 32'(nt_budget_expired));
    $display("budget test done");
    summarize();
  end
endmodule : testbench

// file: rtl/lbc_budget_timer.sv
// start-up time budget counter with expiry flag
`timescale 1ns/100ps
module lbc_budget_timer #(
  parameter int unsigned CW = 32
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          run,
  input  wire logic [CW-1:0] limit,
  output logic      [CW-1:0] count_q,
  output logic               expired_q
);
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_q <= '0;
    end else if (count_q != limit) begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= (count_q == limit);
    end
  end
endmodule : lbc_budget_timer

// file: rtl/lbc_defines.svh
// constants for the loopback two activation control block
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH
`define LBC_ADDR_CTRL        8'h00
`define LBC_ADDR_STATUS      8'h04
`define LBC_ADDR_NT_STATE    8'h08
`define LBC_ADDR_LT_STATE    8'h0C
`define LBC_ADDR_BUDGET      8'h10
`define LBC_ADDR_NT_EVENT    8'h14
`define LBC_ADDR_LT_EVENT    8'h18
`define LBC_CTRL_RESET       32'h0000_0000
`define LBC_CTRL_REGEN_BIT   0
`define LBC_CTRL_COLD_BIT    1
`define LBC_CTRL_CMD_OK_BIT  2
`define LBC_EV_LB2           0
`define LBC_EV_TE_INFO3      1
`define LBC_EV_TE_LOSS       2
`define LBC_EV_DEA0          3
`define LBC_EV_ACT1          4
`define LBC_EV_LINE_LOSS     5
`define LBC_EV_RTN           6
`define LBC_EV_FRAME_SYNC    0
`define LBC_EV_LB_REQ        1
`define LBC_EV_DEACT_REQ     2
`define LBC_EV_SUPERFRAME    3
`define LBC_EV_LT_ACT1       4
`define LBC_EV_RELEASE       5
`define LBC_DEACT_MIN_SF     3
`define LBC_CLK_HZ           25000000
`define LBC_WARM_MS          300
`define LBC_WARM_REG_MS      600
`define LBC_COLD_S           15
`define LBC_COLD_NT_S        5
`define LBC_COLD_LT_S        10
`define LBC_WARM_SPLIT_MS    150
`define LBC_MS_CYC           (`LBC_CLK_HZ / 1000)
`endif

// file: rtl/lbc_loopback_ctrl.sv
// loopback two activation control for both line ends
`timescale 1ns/100ps
`include "lbc_defines.svh"
// Notes on behaviour
// - nt loopback command in synced, te active or transparent goes loop synced
// - entering loop synced from te active or transparent resends info 2
// - all three loop states block terminal info from the nt receiver
// - in loop te active and loop transparent, substitute own info data
// - terminal signal loss in loop active states returns to loop synced
// - lt sends all-zero channel data until transparent
// - loop transparent: both transparent, line data also in info 4
// - lt sends no eoc request before frame sync event
// - loopback request starts activation; loopback command sent at lt synced
// - nt already transparent performs loopback on command
// - loopback release moves lt from loop transparent to synced
// - deact request: pending, deactivation bit 0, three superframes, silence
// - nt synced receiving deactivation bit 0 goes deact pending
// - lt in deact pending never answers activation bit 1
// - nt deactivates on line signal loss
// - lt transparent answers activation 1; nt then goes transparent
// - warm start 300 or 600 ms, cold start 15 s
// - cold start split five seconds nt, ten seconds lt
// - warm start split 150 ms nt, 150 ms lt, or 450 ms lt with the regenerator bit set
module lbc_loopback_ctrl
  import lbc_pkg::*;
#(
  parameter int unsigned WARM_SPLIT_CYC = `LBC_WARM_SPLIT_MS * `LBC_MS_CYC,
  parameter int unsigned COLD_NT_CYC    = `LBC_COLD_NT_S * 1000 * `LBC_MS_CYC,
  parameter int unsigned COLD_LT_CYC    = `LBC_COLD_LT_S * 1000 * `LBC_MS_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output lbc_nt_out_t      nt_out_q,
  output lbc_lt_out_t      lt_out_q,
  output logic             nt_budget_expired,
  output logic             lt_budget_expired
);
  // bus write channel
  logic [7:0]  aw_addr_q;
  logic        aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have_q;
  logic        wr_fire;
  logic [31:0] ctrl_q;
  logic [6:0]  nt_ev_pulse;
  logic [5:0]  lt_ev_pulse;
  logic [7:0]  ar_addr_q;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register and event strobe registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `LBC_CTRL_RESET;
    end else if (wr_fire && aw_addr_q[7:2] == `LBC_ADDR_CTRL >> 2) begin
      ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nt_ev_pulse <= '0;
      lt_ev_pulse <= '0;
    end else begin
      nt_ev_pulse <= '0;
      lt_ev_pulse <= '0;
      if (wr_fire && w_strb_q[0]) begin
        if (aw_addr_q[7:2] == `LBC_ADDR_NT_EVENT >> 2) begin
          nt_ev_pulse <= w_data_q[6:0];
        end
        if (aw_addr_q[7:2] == `LBC_ADDR_LT_EVENT >> 2) begin
          lt_ev_pulse <= w_data_q[5:0];
        end
      end
    end
  end

  // line termination state machine
  lbc_lt_state_t lt_state_q;
  logic [1:0]    sf_cnt_q;
  logic          lb_pending_q;
  logic          frame_sync_q;
  logic          lt_act1;

  // activation answer held off while a loopback command is unconfirmed
  assign lt_act1 = lt_ev_pulse[`LBC_EV_LT_ACT1] && ctrl_q[`LBC_CTRL_CMD_OK_BIT]
                   && !lb_pending_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_sync_q <= 1'b0;
    end else if (lt_state_q == LBC_LT_DEACTIVATED) begin
      frame_sync_q <= 1'b0;
    end else if (lt_ev_pulse[`LBC_EV_FRAME_SYNC]) begin
      frame_sync_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lt_state_q   <= LBC_LT_DEACTIVATED;
      lb_pending_q <= 1'b0;
    end else begin
      if (lt_ev_pulse[`LBC_EV_DEACT_REQ] &&
          lt_state_q != LBC_LT_DEACTIVATED) begin
        lt_state_q <= LBC_LT_DEACT_PENDING;
      end else begin
        unique case (lt_state_q)
          LBC_LT_DEACTIVATED: begin
            if (lt_ev_pulse[`LBC_EV_LB_REQ]) begin
              lt_state_q   <= LBC_LT_ACTIVATING;
              lb_pending_q <= 1'b1;
            end
          end
          LBC_LT_ACTIVATING: begin
            if (lt_ev_pulse[`LBC_EV_FRAME_SYNC]) begin
              lt_state_q <= LBC_LT_SYNCED;
            end
          end
          LBC_LT_SYNCED: begin
            if (lb_pending_q && ctrl_q[`LBC_CTRL_CMD_OK_BIT]) begin
              lt_state_q   <= LBC_LT_LOOP_TRANSPARENT;
              lb_pending_q <= 1'b0;
            end else if (lt_ev_pulse[`LBC_EV_LB_REQ]) begin
              lb_pending_q <= 1'b1;
            end else if (!lb_pending_q && lt_ev_pulse[`LBC_EV_LT_ACT1]) begin
              lt_state_q <= LBC_LT_TRANSPARENT;
            end
          end
          LBC_LT_TRANSPARENT: begin
            if (lt_ev_pulse[`LBC_EV_LB_REQ]) begin
              lt_state_q   <= LBC_LT_SYNCED;
              lb_pending_q <= 1'b1;
            end
          end
          LBC_LT_LOOP_TRANSPARENT: begin
            if (lt_ev_pulse[`LBC_EV_RELEASE]) begin
              lt_state_q <= LBC_LT_SYNCED;
            end
          end
          LBC_LT_DEACT_PENDING: begin
            lb_pending_q <= 1'b0;
            if (sf_cnt_q == 2'(`LBC_DEACT_MIN_SF)) begin
              lt_state_q <= LBC_LT_DEACTIVATED;
            end
          end
          default: lt_state_q <= LBC_LT_DEACTIVATED;
        endcase
      end
    end
  end

  // superframes sent with deactivation bit 0, cleared on entry
  always_ff @(posedge aclk) begin
    if (!aresetn || lt_state_q != LBC_LT_DEACT_PENDING) begin
      sf_cnt_q <= 2'h0;
    end else if (lt_ev_pulse[`LBC_EV_SUPERFRAME] &&
                 sf_cnt_q != 2'(`LBC_DEACT_MIN_SF)) begin
      sf_cnt_q <= sf_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lt_out_q <= '{lt_silence: 1'b1, deactivation_bit: 1'b1,
                    zero_data: 1'b1, default: 1'b0};
    end else begin
      lt_out_q.lt_silence       <= (lt_state_q == LBC_LT_DEACTIVATED);
      lt_out_q.deactivation_bit <= (lt_state_q != LBC_LT_DEACT_PENDING);
      lt_out_q.deact_indication <= (lt_state_q == LBC_LT_DEACT_PENDING) &&
                                   (sf_cnt_q == 2'(`LBC_DEACT_MIN_SF));
      lt_out_q.zero_data        <= (lt_state_q != LBC_LT_TRANSPARENT) &&
                                   (lt_state_q != LBC_LT_LOOP_TRANSPARENT);
      lt_out_q.eoc_allowed      <= frame_sync_q;
      lt_out_q.eoc_loopback_cmd <= frame_sync_q && lb_pending_q &&
                                   (lt_state_q == LBC_LT_SYNCED);
      if (lt_state_q == LBC_LT_DEACT_PENDING) begin
        lt_out_q.activation_bit <= 1'b0;
      end else if (lt_state_q == LBC_LT_TRANSPARENT ||
                   lt_state_q == LBC_LT_LOOP_TRANSPARENT) begin
        lt_out_q.activation_bit <= 1'b1;
      end else if (lt_state_q == LBC_LT_SYNCED && lt_act1) begin
        lt_out_q.activation_bit <= 1'b1;
      end else begin
        lt_out_q.activation_bit <= 1'b0;
      end
    end
  end

  // network termination state machine
  lbc_nt_state_t nt_state_q;
  lbc_nt_state_t nt_resume_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nt_state_q  <= LBC_NT_IDLE;
      nt_resume_q <= LBC_NT_SYNCED;
    end else if (nt_ev_pulse[`LBC_EV_LINE_LOSS]) begin
      nt_state_q <= LBC_NT_IDLE;
    end else begin
      unique case (nt_state_q)
        LBC_NT_IDLE: begin
          if (nt_ev_pulse[`LBC_EV_DEA0] == 1'b0 &&
              lt_out_q.lt_silence == 1'b0) begin
            nt_state_q <= LBC_NT_SYNCED;
          end
        end
        LBC_NT_SYNCED, LBC_NT_TE_ACTIVE, LBC_NT_TRANSPARENT: begin
          if (nt_ev_pulse[`LBC_EV_LB2]) begin
            nt_state_q <= LBC_NT_LOOP_SYNCED;
          end else if (nt_ev_pulse[`LBC_EV_DEA0] ||
                       !lt_out_q.deactivation_bit) begin
            nt_resume_q <= nt_state_q;
            nt_state_q  <= LBC_NT_DEACT_PENDING;
          end else if (nt_state_q == LBC_NT_SYNCED &&
                       nt_ev_pulse[`LBC_EV_TE_INFO3]) begin
            nt_state_q <= LBC_NT_TE_ACTIVE;
          end else if (nt_state_q == LBC_NT_TE_ACTIVE &&
                       (nt_ev_pulse[`LBC_EV_ACT1] ||
                        lt_out_q.activation_bit)) begin
            nt_state_q <= LBC_NT_TRANSPARENT;
          end
        end
        LBC_NT_LOOP_SYNCED: begin
          if (nt_ev_pulse[`LBC_EV_RTN]) begin
            nt_state_q <= LBC_NT_SYNCED;
          end else if (nt_ev_pulse[`LBC_EV_TE_INFO3]) begin
            nt_state_q <= LBC_NT_LOOP_TE_ACTIVE;
          end
        end
        LBC_NT_LOOP_TE_ACTIVE, LBC_NT_LOOP_TRANSPARENT: begin
          if (nt_ev_pulse[`LBC_EV_TE_LOSS]) begin
            nt_state_q <= LBC_NT_LOOP_SYNCED;
          end else if (nt_ev_pulse[`LBC_EV_RTN]) begin
            nt_state_q <= LBC_NT_SYNCED;
          end else if (nt_state_q == LBC_NT_LOOP_TE_ACTIVE &&
                       (nt_ev_pulse[`LBC_EV_ACT1] ||
                        lt_out_q.activation_bit)) begin
            nt_state_q <= LBC_NT_LOOP_TRANSPARENT;
          end
        end
        LBC_NT_DEACT_PENDING: begin
          if (!nt_ev_pulse[`LBC_EV_DEA0] && lt_out_q.deactivation_bit &&
              !lt_out_q.lt_silence) begin
            nt_state_q <= nt_resume_q;
          end
        end
      endcase
    end
  end

  function automatic logic nt_in_loop(input lbc_nt_state_t s);
    return s == LBC_NT_LOOP_SYNCED || s == LBC_NT_LOOP_TE_ACTIVE ||
           s == LBC_NT_LOOP_TRANSPARENT;
  endfunction : nt_in_loop

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nt_out_q <= '0;
    end else begin
      nt_out_q.te_block        <= nt_in_loop(nt_state_q);
      nt_out_q.send_info2      <= nt_state_q == LBC_NT_SYNCED ||
                                  nt_state_q == LBC_NT_LOOP_SYNCED;
      nt_out_q.send_info4      <= nt_state_q == LBC_NT_TRANSPARENT ||
                                  nt_state_q == LBC_NT_LOOP_TRANSPARENT;
      nt_out_q.substitute_data <= nt_state_q == LBC_NT_LOOP_TE_ACTIVE ||
                                  nt_state_q == LBC_NT_LOOP_TRANSPARENT;
      nt_out_q.activation_bit  <= nt_state_q == LBC_NT_TE_ACTIVE ||
                                  nt_state_q == LBC_NT_TRANSPARENT ||
                                  nt_state_q == LBC_NT_LOOP_TE_ACTIVE ||
                                  nt_state_q == LBC_NT_LOOP_TRANSPARENT;
    end
  end

  // start-up budgets: warm split equally unless the regen bit triples lt, cold split five and ten seconds
  logic [31:0] nt_limit;
  logic [31:0] lt_limit;
  logic [31:0] nt_cnt;
  logic [31:0] lt_cnt;
  assign nt_limit = ctrl_q[`LBC_CTRL_COLD_BIT] ? COLD_NT_CYC :
                    WARM_SPLIT_CYC;
  assign lt_limit = ctrl_q[`LBC_CTRL_COLD_BIT] ? COLD_LT_CYC :
                    ctrl_q[`LBC_CTRL_REGEN_BIT] ? 32'(WARM_SPLIT_CYC * 3) :
                    WARM_SPLIT_CYC;

  lbc_budget_timer #(.CW(32)) u_nt_budget (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .run       (nt_state_q == LBC_NT_IDLE && !lt_out_q.lt_silence),
    .limit     (nt_limit),
    .count_q   (nt_cnt),
    .expired_q (nt_budget_expired)
  );

  lbc_budget_timer #(.CW(32)) u_lt_budget (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .run       (lt_state_q == LBC_LT_ACTIVATING),
    .limit     (lt_limit),
    .count_q   (lt_cnt),
    .expired_q (lt_budget_expired)
  );

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      ar_addr_q    <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      ar_addr_q    <= s_axi_araddr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    unique case (ar_addr_q[7:2])
      6'(`LBC_ADDR_CTRL >> 2):     s_axi_rdata = ctrl_q;
      6'(`LBC_ADDR_STATUS >> 2):   s_axi_rdata = {18'h0, nt_budget_expired,
                                     lt_budget_expired, 5'h0, nt_out_q,
                                     2'h0};
      6'(`LBC_ADDR_NT_STATE >> 2): s_axi_rdata = {29'h0, nt_state_q};
      6'(`LBC_ADDR_LT_STATE >> 2): s_axi_rdata = {29'h0, lt_state_q};
      6'(`LBC_ADDR_BUDGET >> 2):   s_axi_rdata = nt_cnt | lt_cnt;
      default:                     s_axi_rdata = 32'h0000_0000;
    endcase
  end
endmodule : lbc_loopback_ctrl

// file: rtl/lbc_pkg.sv
// types for the loopback two activation control block
package lbc_pkg;
  typedef enum logic [2:0] {
    LBC_NT_IDLE, LBC_NT_SYNCED, LBC_NT_TE_ACTIVE, LBC_NT_TRANSPARENT,
    LBC_NT_LOOP_SYNCED, LBC_NT_LOOP_TE_ACTIVE, LBC_NT_LOOP_TRANSPARENT,
    LBC_NT_DEACT_PENDING
  } lbc_nt_state_t;
  typedef enum logic [2:0] {
    LBC_LT_DEACTIVATED, LBC_LT_ACTIVATING, LBC_LT_SYNCED, LBC_LT_TRANSPARENT,
    LBC_LT_LOOP_TRANSPARENT, LBC_LT_DEACT_PENDING
  } lbc_lt_state_t;
  typedef struct packed {
    logic       lt_silence;
    logic       deact_indication;
    logic       activation_bit;
    logic       deactivation_bit;
    logic       eoc_loopback_cmd;
    logic       eoc_allowed;
    logic       zero_data;
  } lbc_lt_out_t;
  typedef struct packed {
    logic       send_info2;
    logic       send_info4;
    logic       te_block;
    logic       substitute_data;
    logic       activation_bit;
  } lbc_nt_out_t;
endpackage : lbc_pkg
